// File: common/eppc_pkg.sv
// Package: constants and types for the EEPROM page-program controller
package eppc_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned ROW_W = 4;
  localparam int unsigned COL_W = 7;
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned ROWS = 16;
  localparam logic [10:0] EE_LO = 11'h000;
  localparam logic [10:0] EE_HI = 11'h7ff;
  // Avalon register offsets (word index, byte address = 4 x index)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h1;
  localparam logic [3:0] OFS_MASK = 4'h2;
  localparam logic [3:0] OFS_PTR = 4'h3;
  localparam logic [3:0] OFS_DATA = 4'h4;
  localparam logic [3:0] OFS_CMD = 4'h5;
  // Control register fields and launch command nibbles
  localparam int unsigned CTRL_SEL_BIT = 0;
  localparam int unsigned CTRL_BUSY_BIT = 1;
  localparam logic [3:0] CMD_FIRST = 4'h5;
  localparam logic [3:0] CMD_SECOND = 4'ha;
  // Status bits: 0 programming done, 1 launch aborted
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_ABORT = 1;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  // Programming time per flagged byte, in ns
  localparam int unsigned PROG_BYTE_NS = 500;
  localparam int unsigned CLK_NS = 100;
  localparam logic [3:0] PROG_BYTE_CYC = 4'((PROG_BYTE_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_PROG  = 3'b100
  } eppc_state_t;
  typedef struct packed {
    logic        valid;
    logic [10:0] addr;
    logic [7:0]  data;
  } eppc_wr_t;
endpackage

// File: logic/eppc_ctrl.sv
// EEPROM page-program controller with Avalon-MM register access
// Functional notes
// RULE_01 - EEPROM mapped 0000h-07FFh when select set
// RULE_02 - Reads return stored byte while selected
// RULE_03 - Write latches bytes, then programs row
// RULE_04 - Page 128 bytes, one to 128 latched
// RULE_05 - Ninth flag per latch, cleared after programming
// RULE_06 - Upper four bits row, lower seven column
// RULE_07 - Last latched page number selects row
// RULE_08 - 50h then A0h launches row programming
// RULE_09 - Busy set on launch, reads blocked
// RULE_10 - Busy cleared when programming finishes
// RULE_11 - Intervening access aborts launch sequence
// RULE_12 - Software disables interrupts, latches per byte
// RULE_13 - Software keeps latches within one page
// RULE_14 - Software reads with single data access
// RULE_15 - Busy ignores launch and latch writes
`timescale 1ns/10ps
`default_nettype none
module eppc_ctrl (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  output var  logic        irq
);
  logic [7:0]            mem [eppc_pkg::ROWS*eppc_pkg::PAGE_BYTES];
  logic [7:0]            latch_data [eppc_pkg::PAGE_BYTES];
  logic [eppc_pkg::PAGE_BYTES-1:0] latch_flag;
  logic [3:0]            page_row;
  logic                  eeprom_space_select;
  logic                  eeprom_prog_busy;
  logic [10:0]           data_pointer;
  logic [1:0]            stat;
  logic [1:0]            mask;
  eppc_pkg::eppc_state_t state;
  logic [6:0]            col;
  logic [3:0]            tick;
  logic [9:0]            prog_cyc;
  logic                  served;
  logic                  acc;
  logic                  fin;
  logic                  wr_ok;
  logic                  rd_ok;
  logic                  ee_hit;
  logic                  launch;
  logic                  abort;
  logic                  prog_done;
  logic                  ee_read_blocked;
  eppc_pkg::eppc_wr_t    lw;

  // True when an address falls in the EEPROM window
  function automatic logic in_window(input logic [10:0] a);
    return (a >= eppc_pkg::EE_LO) && (a <= eppc_pkg::EE_HI);
  endfunction

  // Command nibble match; the low nibble is a don't-care in both launch writes
  function automatic logic cmd_is(input logic [31:0] d, input logic [3:0] code);
    return d[7:4] == code;
  endfunction

  // Access stalls one cycle so read data is registered; served marks the answering cycle
  // Writes and the launch decode act only at the answering edge, when the master sees
  // waitrequest low; acting on the first edge would let a write land before it is acked
  assign acc    = (avs_read | avs_write) & ~served;
  assign fin    = (avs_read | avs_write) & served;
  assign wr_ok  = avs_write & served & avs_byteenable[0];
  assign rd_ok  = avs_read & ~served;
  assign ee_hit = eeprom_space_select & in_window(data_pointer); // RULE_01
  assign ee_read_blocked = eeprom_prog_busy; // RULE_09

  // Latch write request: data port write while the window is selected
  always_comb begin
    lw.valid = wr_ok && avs_address == eppc_pkg::OFS_DATA && ee_hit && !eeprom_prog_busy; // RULE_15
    lw.addr  = data_pointer;
    lw.data  = avs_writedata[7:0];
  end

  // Launch decode: 5xh then Axh back to back; any other access in between aborts
  assign launch = state == eppc_pkg::ST_ARMED && wr_ok && avs_address == eppc_pkg::OFS_CMD
                  && cmd_is(avs_writedata, eppc_pkg::CMD_SECOND); // RULE_08
  // Any completed access other than the second command ends the armed state
  assign abort  = state == eppc_pkg::ST_ARMED && fin && !launch; // RULE_11
  assign prog_done = state == eppc_pkg::ST_PROG && col == 7'h7f
                     && (tick == 4'h0 || !latch_flag[col]); // RULE_04

  // Bus handshake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      served          <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      served          <= acc;
      avs_waitrequest <= ~acc;
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state            <= eppc_pkg::ST_IDLE;
      eeprom_prog_busy <= 1'b0;
      col              <= 7'h00;
      tick             <= 4'h0;
    end else begin
      case (state)
        eppc_pkg::ST_IDLE: begin
          if (wr_ok && avs_address == eppc_pkg::OFS_CMD
              && cmd_is(avs_writedata, eppc_pkg::CMD_FIRST)) begin // RULE_08
            state <= eppc_pkg::ST_ARMED;
          end
        end
        eppc_pkg::ST_ARMED: begin
          if (launch) begin
            state            <= eppc_pkg::ST_PROG;
            eeprom_prog_busy <= 1'b1; // RULE_09
            col              <= 7'h00;
            tick             <= eppc_pkg::PROG_BYTE_CYC;
          end else if (abort) begin
            state <= eppc_pkg::ST_IDLE;
          end
        end
        eppc_pkg::ST_PROG: begin
          // Unflagged columns are skipped in one cycle each
          if (latch_flag[col] && tick != 4'h0) begin
            tick <= tick - 4'h1;
          end else if (prog_done) begin
            state            <= eppc_pkg::ST_IDLE;
            eeprom_prog_busy <= 1'b0; // RULE_10
          end else begin
            col  <= col + 7'h01;
            tick <= eppc_pkg::PROG_BYTE_CYC;
          end
        end
        default: begin
          state            <= eppc_pkg::ST_IDLE;
          eeprom_prog_busy <= 1'b0;
        end
      endcase
    end
  end

  // Column latches and ninth-bit flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_flag <= '0;
      page_row   <= 4'h0;
    end else if (prog_done) begin
      latch_flag <= '0; // RULE_05
    end else if (lw.valid) begin
      latch_data[lw.addr[6:0]] <= lw.data; // RULE_03
      latch_flag[lw.addr[6:0]] <= 1'b1; // RULE_05
      page_row <= lw.addr[10:7]; // RULE_07
    end
  end

  // Array programming: one flagged byte written when its time expires
  always_ff @(posedge clk) begin
    if (state == eppc_pkg::ST_PROG && latch_flag[col] && tick == 4'h1) begin
      mem[{page_row, col}] <= latch_data[col]; // RULE_06
    end
  end

  // Cycles spent in the current programming run, for the length check
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prog_cyc <= 10'h000;
    end else if (launch) begin
      prog_cyc <= 10'h000;
    end else if (state == eppc_pkg::ST_PROG) begin
      prog_cyc <= prog_cyc + 10'h001;
    end
  end

  // Software registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eeprom_space_select <= 1'b0;
      data_pointer        <= 11'h000;
      mask                <= eppc_pkg::MASK_RST;
    end else if (wr_ok) begin
      case (avs_address)
        eppc_pkg::OFS_CTRL: eeprom_space_select <= avs_writedata[eppc_pkg::CTRL_SEL_BIT];
        eppc_pkg::OFS_MASK: mask <= avs_writedata[1:0];
        eppc_pkg::OFS_PTR: data_pointer <= avs_writedata[10:0];
        default: ;
      endcase
    end
  end

  // Sticky events: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat <= eppc_pkg::STAT_RST;
    end else begin
      stat <= (stat & ~((wr_ok && avs_address == eppc_pkg::OFS_STAT) ? avs_writedata[1:0] : 2'h0))
              | {abort, prog_done};
    end
  end

  // Level interrupt, registered so the pin comes straight from a flip-flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat & mask);
    end
  end

  // Read data, registered in the stall cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_ok) begin
      case (avs_address)
        eppc_pkg::OFS_CTRL: avs_readdata <= {30'h0, eeprom_prog_busy, eeprom_space_select};
        eppc_pkg::OFS_STAT: avs_readdata <= {30'h0, stat};
        eppc_pkg::OFS_MASK: avs_readdata <= {30'h0, mask};
        eppc_pkg::OFS_PTR: avs_readdata <= {21'h0, data_pointer};
        eppc_pkg::OFS_DATA: avs_readdata <= (ee_hit && !ee_read_blocked)
                                              ? {24'h0, mem[data_pointer]} : 32'h0000_0000; // RULE_02
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks: handshake
  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    acc |=> !avs_waitrequest ##1 avs_waitrequest) else $error("handshake");
  AST_WRITE_ON_ANSWER: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ok |-> !avs_waitrequest) else $error("write before answer");
  AST_IDLE_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
    !(avs_read || avs_write) |=> avs_waitrequest) else $error("answer without request");

  // Checks: column latches
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    lw.valid && !prog_done |=> latch_flag[$past(lw.addr[6:0])]) else $error("flag missing");
  AST_LATCH_DATA: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    lw.valid |=> latch_data[$past(lw.addr[6:0])] == $past(lw.data))
    else $error("latch data lost");
  AST_FLAGS_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    state != eppc_pkg::ST_PROG && !lw.valid |=> $stable(latch_flag))
    else $error("flag changed");
  AST_SEL_GATES_LATCH: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    !eeprom_space_select && !prog_done |=> $stable(latch_flag))
    else $error("latch unselected");
  AST_ROW_LAST: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    lw.valid && !prog_done |=> page_row == $past(lw.addr[10:7])) else $error("row wrong");
  AST_NO_LATCH_BUSY: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
    eeprom_prog_busy && !prog_done |=> $stable(latch_flag)) else $error("latch while busy");

  // Checks: launch and programming
  AST_ARM_ON_FIRST: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    state == eppc_pkg::ST_IDLE && wr_ok && avs_address == eppc_pkg::OFS_CMD
    && cmd_is(avs_writedata, eppc_pkg::CMD_FIRST) |=> state == eppc_pkg::ST_ARMED)
    else $error("first command missed");
  AST_BUSY_ON_LAUNCH: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    launch |=> eeprom_prog_busy) else $error("busy not set on launch");
  AST_ARMED_ONE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    state == eppc_pkg::ST_ARMED && fin |=> state != eppc_pkg::ST_ARMED)
    else $error("armed past one access");
  AST_ABORT_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    abort |=> state == eppc_pkg::ST_IDLE && !eeprom_prog_busy) else $error("abort failed");
  AST_BUSY_IS_PROG: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    eeprom_prog_busy == (state == eppc_pkg::ST_PROG)) else $error("busy out of step");
  AST_BUSY_HOLDS: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    eeprom_prog_busy && !prog_done |=> eeprom_prog_busy) else $error("busy dropped early");
  AST_NO_REARM: assert property (@(posedge clk) disable iff (sys_rst) // RULE_15
    eeprom_prog_busy && !prog_done |=> state == eppc_pkg::ST_PROG)
    else $error("sequence left programming");
  AST_ROW_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    state == eppc_pkg::ST_PROG && latch_flag[col] && tick == 4'h1
    |=> mem[$past({page_row, col})] == $past(latch_data[col])) else $error("row byte wrong");
  AST_PROG_BOUND: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    state == eppc_pkg::ST_PROG
    |-> prog_cyc < 10'(eppc_pkg::PAGE_BYTES * (eppc_pkg::PROG_BYTE_CYC + 1)))
    else $error("programming overran");
  AST_DONE_CLEARS: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    prog_done |=> !eeprom_prog_busy && latch_flag == '0) else $error("done not cleared");

  // Checks: reads
  AST_READ_BLOCK: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
    rd_ok && avs_address == eppc_pkg::OFS_DATA && eeprom_prog_busy
    |=> avs_readdata == 32'h0) else $error("read while busy");
  AST_UNSEL_READ: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    rd_ok && avs_address == eppc_pkg::OFS_DATA && !eeprom_space_select
    |=> avs_readdata == 32'h0) else $error("read unselected");
  AST_READ_STORED: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    rd_ok && avs_address == eppc_pkg::OFS_DATA && ee_hit && !ee_read_blocked
    |=> avs_readdata == {24'h0, $past(mem[data_pointer])}) else $error("stored byte wrong");

  // Checks: events and interrupt
  AST_DONE_EVENT: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    prog_done |=> stat[eppc_pkg::EV_DONE]) else $error("done event lost");
  AST_ABORT_EVENT: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
    abort |=> stat[eppc_pkg::EV_ABORT]) else $error("abort event lost");
  AST_IRQ: assert property (@(posedge clk) disable iff (sys_rst)
    |(stat & mask) |=> irq) else $error("irq missing");
  AST_IRQ_LOW: assert property (@(posedge clk) disable iff (sys_rst)
    !(|(stat & mask)) |=> !irq) else $error("irq without cause");

  // Main scenarios
  COV_LAUNCH: cover property (@(posedge clk) launch);
  COV_ABORT: cover property (@(posedge clk) abort);
  COV_DONE: cover property (@(posedge clk) prog_done);
  COV_LATCH: cover property (@(posedge clk) lw.valid);
  COV_READ_BLOCKED: cover property (@(posedge clk) rd_ok && ee_read_blocked);
endmodule
`default_nettype wire

// File: sim/eppc_host_model.sv
// Host core model: Avalon-MM master issuing control and data moves
`timescale 1ns/10ps
`default_nettype none
module eppc_host_model (
  input  wire logic        clk,
  output var  logic [3:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata,
  output var  logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // Idle bus at time zero, all byte lanes enabled
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end
  // One move, held until waitrequest is seen low at a rising edge
  task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_address <= ~a; // Released lines stop showing the last value
    avs_writedata <= ~d;
    avs_byteenable <= 4'hf;
    @(posedge clk); // Idle edge, so the next request is a fresh assignment
  endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Testbench: register-level tests of the EEPROM page-program controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        sys_rst;
  wire  [3:0]  adr;
  wire         rd_s;
  wire         wr_s;
  wire  [31:0] wdat;
  wire  [3:0]  be;
  wire  [31:0] rdat;
  wire         wreq;
  wire         irq;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [31:0] q;
  eppc_ctrl eppc_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .irq(irq));
  eppc_host_model eppc_host_model_inst (.clk(clk), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, well above the two programming runs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (n_checks > 0 && miscompares == 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    eppc_host_model_inst.access(1'b1, a, d, 4'hf, r);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    eppc_host_model_inst.access(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, e, q);
  endtask
  // Pointer load then one byte move into a column latch
  task automatic latch(input logic [10:0] p, input logic [7:0] b);
    wr(eppc_pkg::OFS_PTR, {21'h0, p});
    wr(eppc_pkg::OFS_DATA, {24'h0, b});
  endtask
  // Poll busy with a bounded count
  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      eppc_host_model_inst.access(1'b0, eppc_pkg::OFS_CTRL, 32'h0, 4'hf, q);
      if (q[1] === 1'b0) break;
    end
    chk("ctrl idle", 32'h1, q);
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc("stat rst", eppc_pkg::OFS_STAT, 32'h0);
    rdc("mask rst", eppc_pkg::OFS_MASK, 32'h0);
    rdc("ctrl rst", eppc_pkg::OFS_CTRL, 32'h0);
    latch(11'h010, 8'h3c);
    rdc("data unselected", eppc_pkg::OFS_DATA, 32'h0);
    wr(eppc_pkg::OFS_CTRL, 32'h1);
    rdc("unmapped", 4'hf, 32'h0);
    // Mixed pages: last write names row 15
    latch(11'h100, 8'ha5);
    latch(11'h7ff, 8'h5a);
    latch(11'h785, 8'hc3);
    wr(eppc_pkg::OFS_CMD, 32'h50);
    wr(eppc_pkg::OFS_CMD, 32'ha0);
    rdc("ctrl busy", eppc_pkg::OFS_CTRL, 32'h3);
    rdc("data busy", eppc_pkg::OFS_DATA, 32'h0);
    wr(eppc_pkg::OFS_DATA, 32'hff);
    wr(eppc_pkg::OFS_CMD, 32'h50);
    wr(eppc_pkg::OFS_CMD, 32'ha0);
    wait_idle();
    rdc("stat done", eppc_pkg::OFS_STAT, 32'h1);
    irq_is(1'b0);
    wr(eppc_pkg::OFS_MASK, 32'h3);
    rdc("mask set", eppc_pkg::OFS_MASK, 32'h3);
    irq_is(1'b1);
    wr(eppc_pkg::OFS_STAT, 32'h1);
    irq_is(1'b0);
    // Read back through the row/column split
    wr(eppc_pkg::OFS_PTR, 32'h780);
    rdc("row15 col0", eppc_pkg::OFS_DATA, 32'ha5);
    wr(eppc_pkg::OFS_PTR, 32'h7ff);
    rdc("row15 col127", eppc_pkg::OFS_DATA, 32'h5a);
    // Interrupted launch is dropped and flagged
    wr(eppc_pkg::OFS_CMD, 32'h50);
    rdc("ctrl mid", eppc_pkg::OFS_CTRL, 32'h1);
    wr(eppc_pkg::OFS_CMD, 32'ha0);
    rdc("ctrl aborted", eppc_pkg::OFS_CTRL, 32'h1);
    rdc("stat abort", eppc_pkg::OFS_STAT, 32'h2);
    irq_is(1'b1);
    wr(eppc_pkg::OFS_STAT, 32'h2);
    irq_is(1'b0);
    // Second session, one byte, other nibble values
    latch(11'h781, 8'h77);
    wr(eppc_pkg::OFS_CMD, 32'h5f);
    wr(eppc_pkg::OFS_CMD, 32'haf);
    wait_idle();
    wr(eppc_pkg::OFS_PTR, 32'h781);
    rdc("row15 col1", eppc_pkg::OFS_DATA, 32'h77);
    wr(eppc_pkg::OFS_PTR, 32'h785);
    // A write with lane 0 off is dropped
    eppc_host_model_inst.access(1'b1, eppc_pkg::OFS_PTR, 32'h001, 4'he, q);
    rdc("ptr lane0 off", eppc_pkg::OFS_PTR, 32'h785);
    rdc("row15 col5", eppc_pkg::OFS_DATA, 32'hc3);
    complete_run();
  end
endmodule
`default_nettype wire
